// *** crrl_defines.svh ***
// constants for the call/return/reset instruction logic
// assumes a 16-bit instruction word and a 21-bit byte program counter
`ifndef CRRL_DEFINES_SVH
`define CRRL_DEFINES_SVH

// ****************************************************************
// widths
// ****************************************************************
`define CRRL_IW 16
`define CRRL_PC_W 21
`define CRRL_ACC_W 8
`define CRRL_BANK_W 4
`define CRRL_LATU_W 5
`define CRRL_OFS_W 11
`define CRRL_STACK_DEPTH 31

// ****************************************************************
// encodings
// ****************************************************************
`define CRRL_RELATIVE_CALL_OPC 5'h1b
`define CRRL_RETURN_FROM_INTERRUPT_OPC 15'h0008
`define CRRL_RETURN_WITH_LITERAL_OPC 8'h0c
`define CRRL_RESET_WORD 16'h00ff

// ****************************************************************
// reset values and steps
// ****************************************************************
`define CRRL_PC_RST 21'h000000
`define CRRL_PC_STEP 21'h000002
`define CRRL_ACC_RST 8'h00
`define CRRL_STATUS_RST 8'h00
`define CRRL_BANK_RST 4'h0
`define CRRL_LATH_RST 8'h00
`define CRRL_LATU_RST 5'h00
`define CRRL_NOP_WORD 16'h0000

`endif

// *** crrl_pkg.sv ***
// types shared by the call/return/reset instruction logic
// assumes crrl_defines.svh is on the include path
package crrl_pkg;
`include "crrl_defines.svh"

    // instruction cycle phases, gray along q1..q4
    typedef enum logic [1:0] {
        CRRL_Q1 = 2'b00,
        CRRL_Q2 = 2'b01,
        CRRL_Q3 = 2'b11,
        CRRL_Q4 = 2'b10
    } crrl_phase_t;

    typedef struct packed {
        crrl_phase_t phase;
        logic flush;
        logic [`CRRL_IW-1:0] ir;
        logic [`CRRL_PC_W-1:0] pc;
        logic [`CRRL_ACC_W-1:0] accum;
        logic [7:0] status;
        logic [`CRRL_BANK_W-1:0] bank;
        logic high_prio_global_int_enable;
        logic low_prio_global_int_enable;
        logic [7:0] lath;
        logic [`CRRL_LATU_W-1:0] latu;
        logic soft_rst;
    } crrl_state_t;

endpackage : crrl_pkg

// *** crrl_stack_if.sv ***
// request and answer wires between the decoder and its return stack
// assumes one clock shared by both ends
`timescale 1ns/100ps
`include "crrl_defines.svh"
interface crrl_stack_if;
    import crrl_pkg::*;
    logic push;
    logic pop;
    logic clear;
    logic [`CRRL_PC_W-1:0] push_data;
    logic [`CRRL_PC_W-1:0] top;

    modport core (output push, output pop, output clear, output push_data, input top);
    modport stack (input push, input pop, input clear, input push_data, output top);
endinterface : crrl_stack_if

// *** crrl_stack.sv ***
// return-address stack
// assumes push and pop never arrive in the same cycle
`timescale 1ns/100ps
`include "crrl_defines.svh"
module crrl_stack
    import crrl_pkg::*;
#(
    parameter int DEPTH = `CRRL_STACK_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    crrl_stack_if.stack sif
);
    localparam int PW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][`CRRL_PC_W-1:0] mem;
        logic [PW-1:0] ptr;
        logic [`CRRL_PC_W-1:0] top;
        // entry just below the top after the latest push, for the restore check
        logic [`CRRL_PC_W-1:0] below;
        logic below_ok;
    } crrl_stk_state_t;

    crrl_stk_state_t s_q;
    crrl_stk_state_t s_d;

    // ****************************************************************
    // push moves old top one level down, pop brings it back
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        if (sif.clear) begin
            s_d.ptr = '0;
            s_d.top = `CRRL_PC_RST;
            s_d.below_ok = 1'b0;
        end else if (sif.push && s_q.ptr != PW'(DEPTH)) begin
            s_d.below = s_q.top;
            s_d.below_ok = 1'b1;
            s_d.mem[s_q.ptr] = sif.push_data;
            s_d.ptr = s_q.ptr + PW'(1);
            s_d.top = sif.push_data;
        end else if (sif.pop && s_q.ptr != '0) begin
            s_d.ptr = s_q.ptr - PW'(1);
            s_d.below_ok = 1'b0;
            s_d.top = (s_q.ptr > PW'(1)) ? s_q.mem[s_q.ptr - PW'(2)] : `CRRL_PC_RST;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_q.ptr <= '0;
            s_q.top <= `CRRL_PC_RST;
            s_q.mem <= '0;
            s_q.below <= `CRRL_PC_RST;
            s_q.below_ok <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sif.top = s_q.top;

    chk_pop_restores: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (s_q.below_ok && sif.pop && !sif.push && !sif.clear)
        |=> (s_q.top == $past(s_q.below)))
        else $error("pop did not restore previous top");

endmodule : crrl_stack

// *** crrl_decoder.sv ***
// call/return/reset instruction logic of the 8-bit core
// assumes instr_in is the fetched word at prog_addr_out, valid in phase q1
//
// Functional notes
// - relative call: top five bits 11011
// - relative call pushes own address plus two
// - doubled signed offset added to program counter
// - call target is address plus two plus 2n
// - relative call: one word, two cycles
// - software reset equals external master clear
// - word 00ff is software reset
// - return from interrupt pops stack into pc
// - return from interrupt sets one global enable
// - fast bit set restores three shadow registers
// - fast bit clear leaves registers untouched
// - return from interrupt keeps pc latches
// - return with literal loads literal to accumulator
// - return with literal pops stack same phase
// - return with literal keeps pc high latch
// - push shifts old top down one level
`timescale 1ns/100ps
`include "crrl_defines.svh"
module crrl_decoder
    import crrl_pkg::*;
#(
    parameter int STACK_DEPTH = `CRRL_STACK_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [`CRRL_IW-1:0] instr_in,
    input wire logic high_prio_return_in,
    input wire logic [`CRRL_ACC_W-1:0] accumulator_shadow_in,
    input wire logic [7:0] status_shadow_in,
    input wire logic [`CRRL_BANK_W-1:0] bank_select_shadow_in,
    output logic [`CRRL_PC_W-1:0] prog_addr_out,
    output logic [1:0] phase_out,
    output logic [`CRRL_ACC_W-1:0] accumulator_out,
    output logic [7:0] status_out,
    output logic [`CRRL_BANK_W-1:0] bank_select_out,
    output logic high_prio_global_int_enable_out,
    output logic low_prio_global_int_enable_out,
    output logic [7:0] pc_high_latch_out,
    output logic [`CRRL_LATU_W-1:0] pc_upper_latch_out,
    output logic soft_reset_out,
    output logic [`CRRL_PC_W-1:0] stack_top_entry_out
);
    localparam int PCW = `CRRL_PC_W;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic logic is_relative_call(input logic [`CRRL_IW-1:0] w);
        return w[15:11] == `CRRL_RELATIVE_CALL_OPC;
    endfunction : is_relative_call

    function automatic logic is_return_from_interrupt(input logic [`CRRL_IW-1:0] w);
        return w[15:1] == `CRRL_RETURN_FROM_INTERRUPT_OPC;
    endfunction : is_return_from_interrupt

    function automatic logic is_return_with_literal(input logic [`CRRL_IW-1:0] w);
        return w[15:8] == `CRRL_RETURN_WITH_LITERAL_OPC;
    endfunction : is_return_with_literal

    function automatic logic is_reset(input logic [`CRRL_IW-1:0] w);
        return w == `CRRL_RESET_WORD;
    endfunction : is_reset

    function automatic logic [PCW-1:0] rel_offset(input logic [`CRRL_IW-1:0] w);
        return {{(PCW - `CRRL_OFS_W - 1){w[`CRRL_OFS_W-1]}}, w[`CRRL_OFS_W-1:0], 1'b0};
    endfunction : rel_offset

    localparam crrl_state_t RST_STATE = '{
        phase: CRRL_Q1,
        flush: 1'b0,
        ir: `CRRL_NOP_WORD,
        pc: `CRRL_PC_RST,
        accum: `CRRL_ACC_RST,
        status: `CRRL_STATUS_RST,
        bank: `CRRL_BANK_RST,
        high_prio_global_int_enable: 1'b0,
        low_prio_global_int_enable: 1'b0,
        lath: `CRRL_LATH_RST,
        latu: `CRRL_LATU_RST,
        soft_rst: 1'b0
    };

    crrl_state_t s_q;
    crrl_state_t s_d;
    crrl_stack_if sif ();

    // ****************************************************************
    // return stack
    // ****************************************************************
    crrl_stack #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .sif(sif)
    );

    // ****************************************************************
    // phase sequencing and execution
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.soft_rst = 1'b0;
        sif.push = 1'b0;
        sif.pop = 1'b0;
        sif.clear = 1'b0;
        sif.push_data = s_q.pc + `CRRL_PC_STEP;
        case (s_q.phase)
            CRRL_Q1: begin
                s_d.phase = CRRL_Q2;
                // the word fetched during a refill cycle is discarded
                s_d.ir = s_q.flush ? `CRRL_NOP_WORD : instr_in;
            end
            CRRL_Q2: begin
                s_d.phase = CRRL_Q3;
                if (is_reset(s_q.ir)) begin
                    s_d = RST_STATE;
                    s_d.soft_rst = 1'b1;
                    sif.clear = 1'b1;
                end else if (is_relative_call(s_q.ir)) begin
                    sif.push = 1'b1;
                end
            end
            CRRL_Q3: begin
                s_d.phase = CRRL_Q4;
            end
            CRRL_Q4: begin
                s_d.phase = CRRL_Q1;
                s_d.flush = 1'b0;
                if (s_q.flush) begin
                    s_d.flush = 1'b0;
                end else if (is_relative_call(s_q.ir)) begin
                    s_d.pc = s_q.pc + `CRRL_PC_STEP + rel_offset(s_q.ir);
                    s_d.flush = 1'b1;
                end else if (is_return_from_interrupt(s_q.ir)) begin
                    sif.pop = 1'b1;
                    s_d.pc = sif.top;
                    s_d.flush = 1'b1;
                    if (high_prio_return_in) begin
                        s_d.high_prio_global_int_enable = 1'b1;
                    end else begin
                        s_d.low_prio_global_int_enable = 1'b1;
                    end
                    if (s_q.ir[0]) begin
                        s_d.accum = accumulator_shadow_in;
                        s_d.status = status_shadow_in;
                        s_d.bank = bank_select_shadow_in;
                    end
                end else if (is_return_with_literal(s_q.ir)) begin
                    sif.pop = 1'b1;
                    s_d.pc = sif.top;
                    s_d.accum = s_q.ir[7:0];
                    s_d.flush = 1'b1;
                end else begin
                    s_d.pc = s_q.pc + `CRRL_PC_STEP;
                end
            end
            default: begin
                s_d.phase = CRRL_Q1;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prog_addr_out = s_q.pc;
    assign phase_out = s_q.phase;
    assign accumulator_out = s_q.accum;
    assign status_out = s_q.status;
    assign bank_select_out = s_q.bank;
    assign high_prio_global_int_enable_out = s_q.high_prio_global_int_enable;
    assign low_prio_global_int_enable_out = s_q.low_prio_global_int_enable;
    assign pc_high_latch_out = s_q.lath;
    assign pc_upper_latch_out = s_q.latu;
    assign soft_reset_out = s_q.soft_rst;
    assign stack_top_entry_out = sif.top;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic exec_q4;
    assign exec_q4 = s_q.phase == CRRL_Q4 && !s_q.flush;

    chk_relative_call_target: assert property (
        exec_q4 && s_q.ir[15:11] == 5'h1b
        |=> s_q.pc == $past(s_q.pc) + 21'h2 + {{9{$past(s_q.ir[10])}}, $past(s_q.ir[10:0]), 1'b0})
        else $error("relative call target wrong");

    chk_relative_call_push: assert property (
        s_q.phase == CRRL_Q2 && s_q.ir[15:11] == 5'h1b
        |=> sif.top == $past(s_q.pc) + 21'h2)
        else $error("relative call pushed wrong address");

    chk_refill_nop: assert property (
        exec_q4 && (is_relative_call(s_q.ir) || is_return_from_interrupt(s_q.ir) || is_return_with_literal(s_q.ir))
        |=> ##3 (s_q.flush && s_q.ir == 16'h0000) ##1 $stable(s_q.pc))
        else $error("second cycle was not a nop");

    chk_soft_reset: assert property (
        s_q.phase == CRRL_Q2 && s_q.ir == 16'h00ff
        |=> soft_reset_out && s_q.pc == '0 && s_q.accum == '0 && !s_q.high_prio_global_int_enable && !s_q.low_prio_global_int_enable ##1 !soft_reset_out)
        else $error("software reset incomplete");

    chk_return_from_interrupt_gie: assert property (
        exec_q4 && is_return_from_interrupt(s_q.ir)
        |=> s_q.pc == $past(sif.top) && (s_q.high_prio_global_int_enable || s_q.low_prio_global_int_enable)
            && ($past(high_prio_return_in) ? s_q.low_prio_global_int_enable == $past(s_q.low_prio_global_int_enable) : s_q.high_prio_global_int_enable == $past(s_q.high_prio_global_int_enable)))
        else $error("return from interrupt enable wrong");

    chk_fast_restore: assert property (
        exec_q4 && is_return_from_interrupt(s_q.ir) && s_q.ir[0]
        |=> s_q.accum == $past(accumulator_shadow_in) && s_q.status == $past(status_shadow_in)
            && s_q.bank == $past(bank_select_shadow_in))
        else $error("fast restore missing");

    chk_no_restore: assert property (
        exec_q4 && is_return_from_interrupt(s_q.ir) && !s_q.ir[0]
        |=> $stable(s_q.accum) && $stable(s_q.status) && $stable(s_q.bank))
        else $error("registers changed without fast bit");

    chk_latch_hold: assert property (
        exec_q4 && (is_return_from_interrupt(s_q.ir) || is_return_with_literal(s_q.ir))
        |=> $stable(s_q.lath) && $stable(s_q.latu))
        else $error("pc latches changed by return");

    chk_return_with_literal_accum: assert property (
        exec_q4 && s_q.ir[15:8] == 8'h0c
        |=> s_q.accum == $past(s_q.ir[7:0]) && s_q.pc == $past(sif.top))
        else $error("return with literal wrong");

endmodule : crrl_decoder

// *** tb_top.sv ***
// self-checking bench for the call/return/reset instruction logic
// assumes crrl_pkg and crrl_decoder are compiled first; one 200 MHz clock
`timescale 1ns/100ps
module tb_top;
    import crrl_pkg::*;

    // ****************************************************************
    // signals and table
    // ****************************************************************
    typedef struct packed {
        logic [15:0] w;
        logic [3:0] n;
        logic hp;
        logic [7:0] acs;
        logic [7:0] sts;
        logic [3:0] bks;
        logic [20:0] pc;
        logic [7:0] acc;
        logic [7:0] st;
        logic [3:0] bk;
        logic gh;
        logic gl;
        logic [20:0] top;
    } crrl_tb_row_t;

    logic clk_in = 1'h0;
    logic rst_n_in;
    logic [15:0] instr_in;
    logic high_prio_return_in;
    logic [7:0] accumulator_shadow_in;
    logic [7:0] status_shadow_in;
    logic [3:0] bank_select_shadow_in;
    logic [20:0] prog_addr_out;
    logic [1:0] phase_out;
    logic [7:0] accumulator_out;
    logic [7:0] status_out;
    logic [3:0] bank_select_out;
    logic high_prio_global_int_enable_out;
    logic low_prio_global_int_enable_out;
    logic [7:0] pc_high_latch_out;
    logic [4:0] pc_upper_latch_out;
    logic soft_reset_out;
    logic [20:0] stack_top_entry_out;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int pulses;
    crrl_tb_row_t rows [0:8];

    always #2.5 clk_in = ~clk_in;

    crrl_decoder crrl_decoder_i (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .instr_in(instr_in),
        .high_prio_return_in(high_prio_return_in),
        .accumulator_shadow_in(accumulator_shadow_in),
        .status_shadow_in(status_shadow_in),
        .bank_select_shadow_in(bank_select_shadow_in),
        .prog_addr_out(prog_addr_out),
        .phase_out(phase_out),
        .accumulator_out(accumulator_out),
        .status_out(status_out),
        .bank_select_out(bank_select_out),
        .high_prio_global_int_enable_out(high_prio_global_int_enable_out),
        .low_prio_global_int_enable_out(low_prio_global_int_enable_out),
        .pc_high_latch_out(pc_high_latch_out),
        .pc_upper_latch_out(pc_upper_latch_out),
        .soft_reset_out(soft_reset_out),
        .stack_top_entry_out(stack_top_entry_out)
    );

    // ****************************************************************
    // tasks
    // ****************************************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task drive(input crrl_tb_row_t r);
        instr_in <= r.w;
        high_prio_return_in <= r.hp;
        accumulator_shadow_in <= r.acs;
        status_shadow_in <= r.sts;
        bank_select_shadow_in <= r.bks;
    endtask : drive

    task check_row(input crrl_tb_row_t r);
        chk(32'(prog_addr_out), 32'(r.pc));
        chk(32'(accumulator_out), 32'(r.acc));
        chk(32'(status_out), 32'(r.st));
        chk(32'(bank_select_out), 32'(r.bk));
        chk(32'(high_prio_global_int_enable_out), 32'(r.gh));
        chk(32'(low_prio_global_int_enable_out), 32'(r.gl));
        chk(32'(stack_top_entry_out), 32'(r.top));
        chk(32'({pc_upper_latch_out, pc_high_latch_out}), 32'h0);
    endtask : check_row

    // ****************************************************************
    // timeout
    // ****************************************************************
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            test_done;
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        // word, cycles, prio, shadows, then pc acc status bank enables top after it
        rows[0] = '{16'h0000, 4'h4, 1'h0, 8'h00, 8'h00, 4'h0, 21'h000002, 8'h00, 8'h00, 4'h0, 1'h0, 1'h0, 21'h000000};
        rows[1] = '{16'hd805, 4'h8, 1'h0, 8'h00, 8'h00, 4'h0, 21'h00000e, 8'h00, 8'h00, 4'h0, 1'h0, 1'h0, 21'h000004};
        rows[2] = '{16'hdc00, 4'h8, 1'h0, 8'h00, 8'h00, 4'h0, 21'h1ff810, 8'h00, 8'h00, 4'h0, 1'h0, 1'h0, 21'h000010};
        rows[3] = '{16'hdbff, 4'h8, 1'h0, 8'h00, 8'h00, 4'h0, 21'h000010, 8'h00, 8'h00, 4'h0, 1'h0, 1'h0, 21'h1ff812};
        rows[4] = '{16'h0ca5, 4'h8, 1'h0, 8'h00, 8'h00, 4'h0, 21'h1ff812, 8'ha5, 8'h00, 4'h0, 1'h0, 1'h0, 21'h000010};
        rows[5] = '{16'h0011, 4'h8, 1'h1, 8'h3c, 8'hc3, 4'h9, 21'h000010, 8'h3c, 8'hc3, 4'h9, 1'h1, 1'h0, 21'h000004};
        rows[6] = '{16'h0010, 4'h8, 1'h0, 8'h77, 8'h11, 4'h5, 21'h000004, 8'h3c, 8'hc3, 4'h9, 1'h1, 1'h1, 21'h000000};
        rows[7] = '{16'h0000, 4'h4, 1'h0, 8'h00, 8'h00, 4'h0, 21'h000006, 8'h3c, 8'hc3, 4'h9, 1'h1, 1'h1, 21'h000000};
        rows[8] = '{16'h00ff, 4'h2, 1'h0, 8'h00, 8'h00, 4'h0, 21'h000000, 8'h00, 8'h00, 4'h0, 1'h0, 1'h0, 21'h000000};
        rst_n_in = 1'h0;
        instr_in = 16'h0000;
        high_prio_return_in = 1'h0;
        accumulator_shadow_in = 8'h00;
        status_shadow_in = 8'h00;
        bank_select_shadow_in = 4'h0;
        repeat (12) @(posedge clk_in);
        #1;
        check_row(rows[8]);
        chk(32'({soft_reset_out, phase_out}), 32'h0);
        @(posedge clk_in);
        rst_n_in <= 1'h1;
        drive(rows[0]);
        // the word stays on instr_in through the refill cycles and must be ignored
        for (int i = 0; i < 9; i++) begin
            repeat (rows[i].n) @(posedge clk_in);
            if (i < 8) begin
                drive(rows[i + 1]);
            end else begin
                instr_in <= 16'h0000;
            end
            #1;
            check_row(rows[i]);
        end
        // ****************************************************************
        // software reset pulse and restart from address zero
        // ****************************************************************
        pulses = int'(soft_reset_out === 1'h1);
        repeat (2) begin
            @(posedge clk_in);
            #1;
            pulses += int'(soft_reset_out === 1'h1);
        end
        chk(32'(pulses), 32'h1);
        repeat (2) @(posedge clk_in);
        instr_in <= 16'hd805;
        #1;
        chk(32'(prog_addr_out), 32'h2);
        // ****************************************************************
        // external reset in the middle of a call
        // ****************************************************************
        repeat (2) @(posedge clk_in);
        #1;
        chk(32'(stack_top_entry_out), 32'h4);
        @(posedge clk_in);
        rst_n_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        #1;
        check_row(rows[8]);
        // release again: first fetch is q1 at address zero
        @(posedge clk_in);
        rst_n_in <= 1'h1;
        instr_in <= 16'h0000;
        repeat (4) @(posedge clk_in);
        #1;
        chk(32'(prog_addr_out), 32'h2);
        test_done;
    end
endmodule : tb_top
